// *** include/rtc_cfg.svh ***
// Constants for the clock's indirect access port and timebase
`ifndef RTC_CFG_SVH
`define RTC_CFG_SVH
`define RTC_SFR_ADDR 8'hac
`define RTC_SFR_DATA 8'had
`define RTC_SFR_LOCK 8'hae
`define RTC_LOCK_UNLOCKED 8'h02
`define RTC_ADR_AUTO_READ_ENABLE 6
`define RTC_IA_CAP_LAST 5'h03
`define RTC_IA_CTRL 5'h04
`define RTC_IA_OSC_CTRL 5'h05
`define RTC_IA_OSC_CFG 5'h06
`define RTC_IA_ALM_CFG 5'h07
`define RTC_IA_ALM_FIRST 5'h08
`define RTC_IA_ALM_LAST 5'h13
`define RTC_CTRL_POWER 7
`define RTC_CTRL_MCD 6
`define RTC_CTRL_FAIL 5
`define RTC_CTRL_SET 1
`define RTC_CTRL_SNAP 0
`define RTC_XCN_AGC 7
`define RTC_XCN_MODE 6
`define RTC_XCN_BIAS2 5
`define RTC_XCN_VALID 4
`define RTC_XCN_LFO 3
`define RTC_XCF_AUTOSTEP 7
`define RTC_XCF_READY 6
`define RTC_CLK_MHZ 10
`define RTC_MCD_TIME_US 100
`define RTC_MCD_CYCLES 11'(`RTC_MCD_TIME_US * `RTC_CLK_MHZ)
`define RTC_CNT_STEP_OSC 32'h0000_0001
`define RTC_CNT_STEP_LFO 32'h0000_0002
`endif

// *** include/rtc_pkg.sv ***
// Types and shared helpers for the clock's access port and timebase
`include "rtc_cfg.svh"
package rtc_pkg;
  typedef struct packed {
    logic [4:0] addr;
    logic auto_read_enable;
    logic [7:0] data;
    logic [7:0] rdata;
    logic [31:0] counter;
    logic [3:0][7:0] capture;
    logic [11:0][7:0] alarm;
    logic [7:0] alm_cfg;
    logic power;
    logic mcd_en;
    logic fail;
    logic automatic_gain_control;
    logic mode;
    logic bias2;
    logic lfo_en;
    logic valid;
    logic autostep;
    logic [3:0] loadcap;
    logic [3:0] step;
  } rtc_state_t;

  typedef struct packed {
    logic [2:0] sh;
    logic lvl;
    logic chg;
    logic rise;
  } rtc_sync_t;

  typedef struct packed {
    logic [10:0] cnt;
    logic fired;
    logic fail;
  } rtc_mcd_t;

  // Capture and alarm bytes advance the address after each write and each autoread data read
  function automatic logic rtc_auto_inc(input logic [4:0] a);
    rtc_auto_inc = (a <= `RTC_IA_CAP_LAST) || (a >= `RTC_IA_ALM_FIRST && a <= `RTC_IA_ALM_LAST);
  endfunction
endpackage

// *** rtl/rtc_indirect_access_and_timebase.sv ***
// Indirect register access port and timebase selection of the real-time clock
// Notes on behaviour
// - Lock/status register always reads the unlocked value 0x02.
// - Writes to the lock/status register are discarded with no side effect.
// - Address register bit 6 is autoread enable, read/write, reset 0.
// - Address bits 4:0 pick the internal register for indirect access.
// - Indirect writes to capture or alarm bytes advance the address by one; data reads do so only with autoread.
// - Address bits 7 and 5 read zero and ignore writes.
// - Data register carries the byte to or from the selected register.
// - Counter runs from its own timebase, apart from the system clock.
// - Timebase is crystal, self-oscillate, external CMOS or low-frequency oscillator.
// - Mode select bit: 1 crystal, 0 self-oscillate.
// - Oscillator enable bit 1 powers the oscillator circuit.
// - Clock-valid flag reads 0 whenever bias doubling is off.
// - Self-oscillate bias doubling picks about 20 kHz or about 40 kHz.
// - Self-oscillate runs at once with no wait or validity gate.
// - Low-frequency enable both starts and selects that oscillator, no delay.
// - Low-frequency ticks add to counter bit 1, doubling count rate.
// - Autoread: data read returns prepared byte and launches next indirect read.
// - Data write starts indirect write into the selected register.
// - Armed detector flags failure after oscillator idle beyond 100 us.
// - Load-ready flag sets once stepping reaches the programmed load value.
`include "rtc_cfg.svh"
module rtc_indirect_access_and_timebase (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  input wire logic rtc_crystal_in_pin,
  input wire logic low_freq_osc,
  output logic osc_power_enable,
  output logic osc_mode_select,
  output logic bias_double_enable,
  output logic gain_control_enable,
  output logic low_freq_osc_enable,
  output logic [3:0] load_cap_sel,
  output logic osc_fail_flag
);
  import rtc_pkg::*;

  rtc_state_t s_q;
  rtc_state_t s_d;

  logic osc_level;
  logic osc_chg;
  logic osc_rise;
  logic lfo_rise;
  logic mcd_timeout;

  // Timebase edges arrive asynchronously and are filtered here
  rtc_pin_sync u_osc_sync (
    .core_clk(core_clk),
    .rst(rst),
    .pin(rtc_crystal_in_pin),
    .level(osc_level),
    .changed(osc_chg),
    .rose(osc_rise)
  );

  rtc_pin_sync u_lfo_sync (
    .core_clk(core_clk),
    .rst(rst),
    .pin(low_freq_osc),
    .level(),
    .changed(),
    .rose(lfo_rise)
  );

  rtc_missing_clk u_mcd (
    .core_clk(core_clk),
    .rst(rst),
    .enable(s_q.mcd_en & s_q.power & ~s_q.lfo_en),
    .activity(osc_chg),
    .timeout(mcd_timeout)
  );

  // Value seen by an indirect read of internal address a
  function automatic logic [7:0] rtc_ird(input rtc_state_t s, input logic [4:0] a);
    logic [4:0] ai;
    rtc_ird = 8'h00;
    ai = a - `RTC_IA_ALM_FIRST;
    if (a <= `RTC_IA_CAP_LAST) begin
      rtc_ird = s.capture[a[1:0]];
    end else if (a >= `RTC_IA_ALM_FIRST && a <= `RTC_IA_ALM_LAST) begin
      rtc_ird = s.alarm[ai[3:0]];
    end else if (a == `RTC_IA_CTRL) begin
      rtc_ird[`RTC_CTRL_POWER] = s.power;
      rtc_ird[`RTC_CTRL_MCD] = s.mcd_en;
      rtc_ird[`RTC_CTRL_FAIL] = s.fail;
    end else if (a == `RTC_IA_OSC_CTRL) begin
      rtc_ird[`RTC_XCN_AGC] = s.automatic_gain_control;
      rtc_ird[`RTC_XCN_MODE] = s.mode;
      rtc_ird[`RTC_XCN_BIAS2] = s.bias2;
      rtc_ird[`RTC_XCN_VALID] = s.valid;
      rtc_ird[`RTC_XCN_LFO] = s.lfo_en;
    end else if (a == `RTC_IA_OSC_CFG) begin
      rtc_ird[`RTC_XCF_AUTOSTEP] = s.autostep;
      rtc_ird[`RTC_XCF_READY] = s.power && (s.step == s.loadcap);
      rtc_ird[3:0] = s.loadcap;
    end else if (a == `RTC_IA_ALM_CFG) begin
      rtc_ird = s.alm_cfg;
    end
  endfunction

  logic tick;
  logic [31:0] cnt_step;
  logic [4:0] nxt_addr;
  logic [4:0] wi;
  logic acc_addr;
  logic acc_data;
  logic acc_lock;

  always_comb begin
    s_d = s_q;
    acc_addr = sfr_addr == `RTC_SFR_ADDR;
    acc_data = sfr_addr == `RTC_SFR_DATA;
    acc_lock = sfr_addr == `RTC_SFR_LOCK;
    nxt_addr = s_q.addr;
    wi = s_q.addr - `RTC_IA_ALM_FIRST;

    // Low-frequency enable overrides the oscillator as the tick source
    if (s_q.lfo_en) begin
      tick = lfo_rise;
      cnt_step = `RTC_CNT_STEP_LFO;
    end else begin
      // No start-up gate: self-oscillate and crystal count from the first edge
      tick = s_q.power & osc_rise;
      cnt_step = `RTC_CNT_STEP_OSC;
    end
    if (tick) begin
      s_d.counter = s_q.counter + cnt_step;
    end

    // Load capacitance steps up one notch per timebase tick
    if (!s_q.power) begin
      s_d.step = 4'h0;
    end else if (!s_q.autostep || s_q.step > s_q.loadcap) begin
      s_d.step = s_q.loadcap;
    end else if (tick && s_q.step < s_q.loadcap) begin
      s_d.step = s_q.step + 4'h1;
    end

    // Register read answers one cycle after the strobe
    if (sfr_rd) begin
      if (acc_lock) begin
        s_d.rdata = `RTC_LOCK_UNLOCKED;
      end else if (acc_addr) begin
        s_d.rdata = {1'b0, s_q.auto_read_enable, 1'b0, s_q.addr};
      end else if (acc_data) begin
        s_d.rdata = s_q.data;
        if (s_q.auto_read_enable) begin
          // Consumed byte advances the pointer at capture and alarm addresses, next byte is fetched
          if (rtc_auto_inc(s_q.addr)) begin
            nxt_addr = s_q.addr + 5'h01;
          end
          s_d.addr = nxt_addr;
          s_d.data = rtc_ird(s_q, nxt_addr);
        end
      end else begin
        s_d.rdata = 8'h00;
      end
    end

    // Lock/status writes fall through untouched
    if (sfr_wr && acc_addr) begin
      s_d.auto_read_enable = sfr_wdata[`RTC_ADR_AUTO_READ_ENABLE];
      s_d.addr = sfr_wdata[4:0];
      // Prefetch so a plain data read returns the selected register
      s_d.data = rtc_ird(s_q, sfr_wdata[4:0]);
    end else if (sfr_wr && acc_data) begin
      s_d.data = sfr_wdata;
      if (s_q.addr <= `RTC_IA_CAP_LAST) begin
        s_d.capture[s_q.addr[1:0]] = sfr_wdata;
      end else if (s_q.addr >= `RTC_IA_ALM_FIRST && s_q.addr <= `RTC_IA_ALM_LAST) begin
        s_d.alarm[wi[3:0]] = sfr_wdata;
      end else if (s_q.addr == `RTC_IA_CTRL) begin
        s_d.power = sfr_wdata[`RTC_CTRL_POWER];
        s_d.mcd_en = sfr_wdata[`RTC_CTRL_MCD];
        // Software may only clear the fail flag
        if (!sfr_wdata[`RTC_CTRL_FAIL]) begin
          s_d.fail = 1'b0;
        end
        if (sfr_wdata[`RTC_CTRL_SET]) begin
          s_d.counter = s_q.capture;
        end
        if (sfr_wdata[`RTC_CTRL_SNAP]) begin
          s_d.capture = s_q.counter;
        end
      end else if (s_q.addr == `RTC_IA_OSC_CTRL) begin
        s_d.automatic_gain_control = sfr_wdata[`RTC_XCN_AGC];
        s_d.mode = sfr_wdata[`RTC_XCN_MODE];
        s_d.bias2 = sfr_wdata[`RTC_XCN_BIAS2];
        s_d.lfo_en = sfr_wdata[`RTC_XCN_LFO];
      end else if (s_q.addr == `RTC_IA_OSC_CFG) begin
        s_d.autostep = sfr_wdata[`RTC_XCF_AUTOSTEP];
        s_d.loadcap = sfr_wdata[3:0];
      end else if (s_q.addr == `RTC_IA_ALM_CFG) begin
        s_d.alm_cfg = sfr_wdata;
      end
      if (rtc_auto_inc(s_q.addr)) begin
        s_d.addr = s_q.addr + 5'h01;
      end
    end

    // A detector event in the clearing cycle still sets the flag
    if (mcd_timeout) begin
      s_d.fail = 1'b1;
    end

    // Valid needs bias doubling and crystal mode; a rising edge while powered confirms it
    if (!s_d.bias2 || !s_d.power || !s_d.mode) begin
      s_d.valid = 1'b0;
    end else if (osc_rise) begin
      s_d.valid = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign sfr_rdata = s_q.rdata;
  assign osc_power_enable = s_q.power;
  assign osc_mode_select = s_q.mode;
  assign bias_double_enable = s_q.bias2;
  assign gain_control_enable = s_q.automatic_gain_control;
  assign low_freq_osc_enable = s_q.lfo_en;
  assign load_cap_sel = s_q.step;
  assign osc_fail_flag = s_q.fail;
endmodule

// *** rtl/rtc_missing_clk.sv ***
// One-shot detector for an oscillator that stops toggling
`include "rtc_cfg.svh"
module rtc_missing_clk (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic enable,
  input wire logic activity,
  output logic timeout
);
  import rtc_pkg::*;
  rtc_mcd_t s_q;
  rtc_mcd_t s_d;

  always_comb begin
    s_d = s_q;
    s_d.fail = 1'b0;
    if (!enable || activity) begin
      s_d.cnt = '0;
      s_d.fired = 1'b0;
    end else if (!s_q.fired) begin
      if (s_q.cnt == `RTC_MCD_CYCLES) begin
        // Fires once per stall; re-armed by the next edge
        s_d.fail = 1'b1;
        s_d.fired = 1'b1;
      end else begin
        s_d.cnt = s_q.cnt + 11'h001;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign timeout = s_q.fail;
endmodule

// *** rtl/rtc_pin_sync.sv ***
// Three-stage input synchroniser with agreement filter and edge pulses
module rtc_pin_sync (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic pin,
  output logic level,
  output logic changed,
  output logic rose
);
  import rtc_pkg::*;
  rtc_sync_t s_q;
  rtc_sync_t s_d;

  always_comb begin
    s_d = s_q;
    s_d.sh = {s_q.sh[1:0], pin};
    // Stage one feeds only stage two; later stages must agree
    if (s_q.sh[1] == s_q.sh[2]) begin
      s_d.lvl = s_q.sh[2];
    end
    s_d.chg = s_d.lvl != s_q.lvl;
    s_d.rise = s_d.lvl & ~s_q.lvl;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign level = s_q.lvl;
  assign changed = s_q.chg;
  assign rose = s_q.rise;
endmodule

// *** verification/rtc_iat_asserts.sv ***
// Port-level checker for the clock access port
module rtc_iat_asserts (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_rd,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_rdata,
  input wire logic osc_power_enable,
  input wire logic osc_mode_select,
  input wire logic low_freq_osc_enable,
  input wire logic [3:0] load_cap_sel,
  input wire logic osc_fail_flag
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence s_rd(a);
    sfr_rd && sfr_addr == a;
  endsequence
  a_lock_reads: assert property (s_rd(8'hae) |=> sfr_rdata == 8'h02)
    else $error("lock read wrong");
  a_adr_zero_bits: assert property (s_rd(8'hac) |=> !sfr_rdata[7] && !sfr_rdata[5])
    else $error("address spare bits set");
  a_rdata_holds: assert property (!sfr_rd |=> $stable(sfr_rdata))
    else $error("read data moved");
  a_fail_sticky: assert property (osc_fail_flag && !sfr_wr |=> osc_fail_flag)
    else $error("fail flag dropped");
  a_fail_cause: assert property ($rose(osc_fail_flag) |-> osc_power_enable && !low_freq_osc_enable)
    else $error("fail flag without armed oscillator");
  a_power_by_write: assert property ($changed(osc_power_enable) |-> $past(sfr_wr))
    else $error("power moved without write");
  a_mode_by_write: assert property ($changed(osc_mode_select) |-> $past(sfr_wr))
    else $error("mode moved without write");
  a_lfo_by_write: assert property ($changed(low_freq_osc_enable) |-> $past(sfr_wr))
    else $error("lfo enable moved without write");
  a_load_unpowered: assert property (!osc_power_enable [*2] |-> load_cap_sel == 4'h0)
    else $error("load cap stepped while unpowered");
endmodule

bind rtc_indirect_access_and_timebase rtc_iat_asserts u_chk (.core_clk(core_clk), .rst(rst),
  .sfr_addr(sfr_addr), .sfr_rd(sfr_rd), .sfr_wr(sfr_wr), .sfr_rdata(sfr_rdata),
  .osc_power_enable(osc_power_enable), .osc_mode_select(osc_mode_select),
  .low_freq_osc_enable(low_freq_osc_enable), .load_cap_sel(load_cap_sel), .osc_fail_flag(osc_fail_flag));

// *** verification/rtc_osc_model.sv ***
// Behavioural oscillator and low-frequency sources for the timebase pins
module rtc_osc_model (
  input wire logic osc_run,
  input wire logic lfo_run,
  output logic osc_pin,
  output logic lfo_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  // Stopped sources hold their level, as a dead oscillator would
  initial begin
    osc_pin = 1'b0;
    lfo_pin = 1'b0;
  end
  always #1530 if (osc_run) osc_pin = ~osc_pin;
  always #3070 if (lfo_run) lfo_pin = ~lfo_pin;
endmodule

// *** verification/tb_top.sv ***
// Self-checking bench for the clock access port and timebase
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] sfr_addr = 8'h00;
  logic sfr_wr = 1'b0;
  logic sfr_rd = 1'b0;
  logic [7:0] sfr_wdata = 8'h00;
  logic [7:0] sfr_rdata;
  logic osc_run = 1'b0;
  logic lfo_run = 1'b0;
  logic osc_pin, lfo_pin, pwr, mode, bias2, automatic_gain_control, lfo_en, fail;
  logic [3:0] load_cap_sel;
  int error_cnt = 0;
  int checks = 0;
  int lfo_edges = 0;
  int osc_edges = 0;
  always #50 core_clk = ~core_clk;
  always @(posedge lfo_pin) lfo_edges++;
  always @(posedge osc_pin) osc_edges++;
  rtc_osc_model u_osc (.osc_run(osc_run), .lfo_run(lfo_run), .osc_pin(osc_pin), .lfo_pin(lfo_pin));
  rtc_indirect_access_and_timebase u_dut (.core_clk(core_clk), .rst(rst), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .rtc_crystal_in_pin(osc_pin), .low_freq_osc(lfo_pin), .osc_power_enable(pwr),
    .osc_mode_select(mode), .bias_double_enable(bias2), .gain_control_enable(automatic_gain_control),
    .low_freq_osc_enable(lfo_en), .load_cap_sel(load_cap_sel), .osc_fail_flag(fail));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge core_clk);
    sfr_wr = 1'b0;
  endtask
  // Whole-byte reads only: an autoread data read of a capture or alarm byte moves the pointer
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge core_clk);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge core_clk);
    sfr_rd = 1'b0;
    d = sfr_rdata;
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    chk(32'(d), 32'(exp));
  endtask
  task automatic iw(input logic [7:0] ia, input logic [7:0] d);
    wr(8'hac, ia);
    wr(8'had, d);
  endtask
  // Address write prefetches, so a plain data read sees the selected byte
  task automatic ir(input logic [7:0] ia, input logic [7:0] exp);
    wr(8'hac, ia);
    rc(8'had, exp);
  endtask
  // Control byte must carry the power bit when the oscillator has to keep running
  task automatic snap(input logic [7:0] ctl, output logic [31:0] v);
    logic [7:0] b;
    iw(8'h04, ctl);
    wr(8'hac, 8'h40);
    for (int i = 0; i < 4; i++) begin
      rd(8'had, b);
      v[8*i +: 8] = b;
    end
  endtask
  task automatic t_lock;
    rc(8'hae, 8'h02);
    rc(8'hac, 8'h00);
    wr(8'hac, 8'hff);
    rc(8'hac, 8'h5f);
    wr(8'hae, 8'h00);
    rc(8'hae, 8'h02);
    rc(8'hac, 8'h5f);
    rc(8'haf, 8'h00);
  endtask
  task automatic t_burst;
    wr(8'hac, 8'h08);
    for (int i = 0; i < 4; i++) wr(8'had, 8'(i + 5));
    rc(8'hac, 8'h0c);
    wr(8'hac, 8'h48);
    for (int i = 0; i < 4; i++) rc(8'had, 8'(i + 5));
    rc(8'hac, 8'h4c);
    iw(8'h07, 8'h3c);
    rc(8'hac, 8'h07);
    ir(8'h07, 8'h3c);
  endtask
  task automatic t_fail;
    iw(8'h04, 8'hc0);
    chk(32'(pwr), 32'h1);
    repeat (900) @(negedge core_clk);
    chk(32'(fail), 32'h0);
    repeat (200) @(negedge core_clk);
    chk(32'(fail), 32'h1);
    iw(8'h04, 8'h80);
    chk(32'(fail), 32'h0);
  endtask
  task automatic t_osc;
    logic [31:0] v0, v1;
    int n;
    iw(8'h05, 8'h40);
    chk(32'({mode, bias2}), 32'h2);
    osc_run = 1'b1;
    repeat (200) @(negedge core_clk);
    ir(8'h05, 8'h40);
    iw(8'h05, 8'h20);
    chk(32'({mode, bias2}), 32'h1);
    osc_run = 1'b0;
    repeat (20) @(negedge core_clk);
    snap(8'h81, v0);
    n = osc_edges;
    osc_run = 1'b1;
    repeat (200) @(negedge core_clk);
    osc_run = 1'b0;
    repeat (20) @(negedge core_clk);
    n = osc_edges - n;
    snap(8'h81, v1);
    chk(v1 - v0, 32'(n));
    osc_run = 1'b1;
    iw(8'h05, 8'he0);
    repeat (200) @(negedge core_clk);
    ir(8'h05, 8'hf0);
    chk(32'(automatic_gain_control), 32'h1);
    osc_run = 1'b0;
  endtask
  task automatic t_lfo;
    logic [31:0] v0, v1;
    int n;
    iw(8'h05, 8'h08);
    chk(32'(lfo_en), 32'h1);
    snap(8'h01, v0);
    n = lfo_edges;
    lfo_run = 1'b1;
    repeat (400) @(negedge core_clk);
    lfo_run = 1'b0;
    // Count only after the last edge has settled through the synchroniser
    repeat (20) @(negedge core_clk);
    n = lfo_edges - n;
    snap(8'h01, v1);
    chk(v1 - v0, 32'(2 * n));
  endtask
  task automatic t_xtal;
    logic [7:0] b;
    logic ok;
    iw(8'h05, 8'h60);
    iw(8'h06, 8'h85);
    osc_run = 1'b1;
    iw(8'h04, 8'h80);
    chk(32'(load_cap_sel), 32'h0);
    // Start-up wait cut short to fit the run budget; the model needs no settling
    repeat (200) @(negedge core_clk);
    ok = 1'b0;
    for (int i = 0; i < 20 && !ok; i++) begin
      wr(8'hac, 8'h05);
      rd(8'had, b);
      ok = b[4];
    end
    chk(32'(ok), 32'h1);
    ok = 1'b0;
    for (int i = 0; i < 20 && !ok; i++) begin
      wr(8'hac, 8'h06);
      rd(8'had, b);
      ok = b[6];
    end
    chk(32'(ok), 32'h1);
    chk(32'(load_cap_sel), 32'h5);
    ir(8'h06, 8'hc5);
    iw(8'h05, 8'hc0);
    ir(8'h05, 8'hc0);
    iw(8'h04, 8'hc0);
    repeat (20000) @(negedge core_clk);
    chk(32'(fail), 32'h0);
    // Wake-flag clear belongs to the power unit, outside this block
  endtask
  task automatic t_cmos;
    iw(8'h04, 8'h00);
    iw(8'h05, 8'h40);
    osc_run = 1'b1;
    iw(8'h04, 8'hc0);
    repeat (20000) @(negedge core_clk);
    chk(32'(fail), 32'h0);
    ir(8'h05, 8'h40);
    iw(8'h04, 8'h00);
    osc_run = 1'b0;
  endtask
  task automatic tally_and_finish;
    if (error_cnt == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (6) @(negedge core_clk);
    rst = 1'b0;
    t_lock;
    t_burst;
    t_fail;
    t_osc;
    t_lfo;
    t_xtal;
    t_cmos;
    tally_and_finish;
  end
  initial begin
    repeat (100000) @(posedge core_clk);
    error_cnt++;
    tally_and_finish;
  end
endmodule
